// ==== verilog/qcs_map.svh ====
// Register offsets, field positions and reset values of the QoS classifier and scheduler.
// Operation
// RULE1: Take three-bit VLAN priority, seven highest.
// RULE2: Take IPv4 precedence, seven highest, zero lowest.
// RULE3: Code point is six bits; two reserved ignored.
// RULE4: Top three code-point bits form class selector.
// RULE5: 64-entry code-point table, default eight per queue.
// RULE6: Writable VLAN-priority-to-queue table, applies immediately.
// RULE7: Per-port default priority used when nothing trusted.
// RULE8: Global enable and four-way trust selection.
// RULE9: Port trust off uses port default only.
// RULE10: Per-port remarking of priority, code point, precedence.
// RULE11: Weighted round robin serves queues by weight.
// RULE12: Strict priority serves highest non-empty queue.
// RULE13: Precedence-to-queue table used in precedence trust.
// RULE14: Combined mode: IP by code point, others VLAN.
`ifndef QCS_MAP_SVH
`define QCS_MAP_SVH

// =====================================================================
// Register offsets (byte addresses)
`define QCS_CTRL_OFS      12'h000
`define QCS_PORT_OFS      12'h004
`define QCS_PRI_MAP_OFS   12'h008
`define QCS_PREC_MAP_OFS  12'h00C
`define QCS_WEIGHT_OFS    12'h010
`define QCS_STATUS_OFS    12'h014
`define QCS_DSCP_BASE     12'h100
`define QCS_DSCP_LAST     12'h1FC

// =====================================================================
// Field positions
`define QCS_CTRL_EN       0
`define QCS_CTRL_TRUST_LO 1
`define QCS_CTRL_WRR      3
`define QCS_PORT_TRUST    0
`define QCS_PORT_DEF_LO   1
`define QCS_PORT_RMK_PRI  4
`define QCS_PORT_RMK_DSCP 5
`define QCS_PORT_RMK_PREC 6

// =====================================================================
// Reset values
`define QCS_CTRL_RST      4'h0
`define QCS_PORT_RST      7'h01
`define QCS_MAP_RST       24'hFAC688
`define QCS_WEIGHT_RST    32'h11111111

`endif

// ==== verilog/qcs_pkg.sv ====
// Types shared by the QoS classifier and scheduler.
package qcs_pkg;

   typedef enum logic [1:0] {
      QCS_TRUST_COS  = 2'h0,
      QCS_TRUST_DSCP = 2'h1,
      QCS_COMBINED_TRUST_MODE = 2'h2,
      QCS_TRUST_PREC = 2'h3
   } qcs_trust_t;

   typedef enum logic [1:0] {
      QCS_SRC_DEFAULT = 2'h0,
      QCS_SRC_VLAN    = 2'h1,
      QCS_SRC_DSCP    = 2'h2,
      QCS_SRC_PREC    = 2'h3
   } qcs_src_t;

endpackage

// ==== verilog/qcs_classifier_scheduler.sv ====
// QoS classifier with remarking and an eight-queue egress scheduler.
`include "qcs_map.svh"

module qcs_classifier_scheduler (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [31:0] reg_rdata,
   input wire logic frm_valid,
   input wire logic frm_has_vlan,
   input wire logic [2:0] frm_vlan_pri,
   input wire logic frm_is_ipv4,
   input wire logic [7:0] frm_tos,
   output logic cls_valid,
   output logic [2:0] cls_queue,
   output logic [2:0] cls_vlan_pri,
   output logic [7:0] cls_tos,
   input wire logic [7:0] q_nonempty,
   input wire logic sched_ready,
   output logic grant_valid,
   output logic [2:0] grant_queue
);

   // =====================================================================
   // Helpers
   function automatic logic [2:0] map_lookup(input logic [23:0] tbl, input logic [2:0] idx);
      map_lookup = tbl[3 * idx +: 3];
   endfunction

   // Code-point table entries sit one word apart above the table base.
   function automatic logic [5:0] dscp_entry(input logic [11:0] addr);
      dscp_entry = addr[7:2];
   endfunction

   // A zero weight still gets one turn so no queue starves.
   function automatic logic [3:0] weight_of(input logic [31:0] w, input logic [2:0] idx);
      weight_of = (w[4 * idx +: 4] == 4'h0) ? 4'h1 : w[4 * idx +: 4];
   endfunction

   // =====================================================================
   // Register file
   logic [3:0] ctrl_q;
   logic [6:0] port_q;
   logic [23:0] pri_map_q;
   logic [23:0] prec_map_q;
   logic [31:0] weight_q;
   logic [2:0] dscp_map_q [64];
   logic [2:0] last_queue_q;
   logic [1:0] last_src_q;
   logic [31:0] rdata_d;
   logic dscp_hit;

   assign dscp_hit = (reg_addr >= `QCS_DSCP_BASE) && (reg_addr <= `QCS_DSCP_LAST);

   // Writes wait for ce, so a stalled core keeps its settings.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_q <= `QCS_CTRL_RST;
         port_q <= `QCS_PORT_RST;
         pri_map_q <= `QCS_MAP_RST;
         prec_map_q <= `QCS_MAP_RST;
         weight_q <= `QCS_WEIGHT_RST;
      end else if (ce && reg_we) begin
         unique case (reg_addr)
            `QCS_CTRL_OFS: ctrl_q <= reg_wdata[3:0]; // RULE8
            `QCS_PORT_OFS: port_q <= reg_wdata[6:0]; // RULE7
            `QCS_PRI_MAP_OFS: pri_map_q <= reg_wdata[23:0]; // RULE6
            `QCS_PREC_MAP_OFS: prec_map_q <= reg_wdata[23:0]; // RULE13
            `QCS_WEIGHT_OFS: weight_q <= reg_wdata; // RULE11
            default: begin
            end
         endcase
      end
   end

   // Each block of eight code points resets to one queue.
   generate
      for (genvar g = 0; g < 64; g++) begin : g_dscp
         always_ff @(posedge clk) begin
            if (!resetn) begin
               dscp_map_q[g] <= 3'(g / 8); // RULE5
            end else if (ce && reg_we && dscp_hit && dscp_entry(reg_addr) == 6'(g)) begin
               dscp_map_q[g] <= reg_wdata[2:0]; // RULE5
            end
         end
      end
   endgenerate

   always_comb begin
      rdata_d = 32'h0;
      if (dscp_hit) begin
         rdata_d = {29'h0, dscp_map_q[dscp_entry(reg_addr)]};
      end else begin
         unique case (reg_addr)
            `QCS_CTRL_OFS: rdata_d = {28'h0, ctrl_q};
            `QCS_PORT_OFS: rdata_d = {25'h0, port_q};
            `QCS_PRI_MAP_OFS: rdata_d = {8'h0, pri_map_q};
            `QCS_PREC_MAP_OFS: rdata_d = {8'h0, prec_map_q};
            `QCS_WEIGHT_OFS: rdata_d = weight_q;
            `QCS_STATUS_OFS: rdata_d = {16'h0, q_nonempty, 3'h0, last_src_q, last_queue_q};
            default: rdata_d = 32'h0;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         reg_rdata <= 32'h0;
      end else if (ce) begin
         reg_rdata <= reg_re ? rdata_d : 32'h0;
      end
   end

   // =====================================================================
   // Classification
   logic qos_en;
   qcs_pkg::qcs_trust_t trust;
   logic port_trust;
   logic [2:0] def_pri;
   logic [5:0] dscp;
   logic [2:0] prec;
   logic [2:0] class_selector_code;
   qcs_pkg::qcs_src_t src;
   logic [2:0] res_pri;
   logic [2:0] queue_d;
   logic [2:0] vlan_pri_d;
   logic [7:0] tos_d;

   assign qos_en = ctrl_q[`QCS_CTRL_EN];
   assign trust = qcs_pkg::qcs_trust_t'(ctrl_q[`QCS_CTRL_TRUST_LO +: 2]);
   assign port_trust = port_q[`QCS_PORT_TRUST];
   assign def_pri = port_q[`QCS_PORT_DEF_LO +: 3];
   // Bit 5 of the field is the byte's most significant bit.
   assign dscp = frm_tos[7:2]; // RULE3
   assign prec = frm_tos[7:5]; // RULE2
   assign class_selector_code = dscp[5:3]; // RULE4

   // In the code-point and precedence modes a frame without an IPv4 header falls back to the port default.
   always_comb begin
      src = qcs_pkg::QCS_SRC_DEFAULT;
      if (port_trust) begin // RULE9
         unique case (trust) // RULE8
            qcs_pkg::QCS_TRUST_COS:
               if (frm_has_vlan) src = qcs_pkg::QCS_SRC_VLAN; // RULE1
            qcs_pkg::QCS_TRUST_DSCP:
               if (frm_is_ipv4) src = qcs_pkg::QCS_SRC_DSCP; // RULE14
            qcs_pkg::QCS_COMBINED_TRUST_MODE: begin
               if (frm_is_ipv4) begin
                  src = qcs_pkg::QCS_SRC_DSCP; // RULE14
               end else if (frm_has_vlan) begin
                  src = qcs_pkg::QCS_SRC_VLAN; // RULE14
               end
            end
            qcs_pkg::QCS_TRUST_PREC:
               if (frm_is_ipv4) src = qcs_pkg::QCS_SRC_PREC; // RULE13
         endcase
      end
   end

   always_comb begin
      res_pri = def_pri; // RULE7
      queue_d = map_lookup(pri_map_q, def_pri); // RULE7
      unique case (src)
         qcs_pkg::QCS_SRC_VLAN: begin
            res_pri = frm_vlan_pri;
            queue_d = map_lookup(pri_map_q, frm_vlan_pri); // RULE6
         end
         qcs_pkg::QCS_SRC_DSCP: begin
            res_pri = class_selector_code;
            queue_d = dscp_map_q[dscp]; // RULE5
         end
         qcs_pkg::QCS_SRC_PREC: begin
            res_pri = prec;
            queue_d = map_lookup(prec_map_q, prec); // RULE13
         end
         default: begin
         end
      endcase
      vlan_pri_d = frm_vlan_pri;
      tos_d = frm_tos;
      if (!qos_en) begin
         // With classification off every frame lands in the lowest queue untouched.
         queue_d = 3'h0; // RULE8
      end else begin
         if (port_q[`QCS_PORT_RMK_PRI]) vlan_pri_d = res_pri; // RULE10
         // Code point remark wins over precedence since it covers those bits.
         if (port_q[`QCS_PORT_RMK_PREC]) tos_d[7:5] = res_pri; // RULE10
         if (port_q[`QCS_PORT_RMK_DSCP]) tos_d[7:2] = {res_pri, 3'h0}; // RULE10
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cls_valid <= 1'b0;
         cls_queue <= 3'h0;
         cls_vlan_pri <= 3'h0;
         cls_tos <= 8'h0;
      end else if (ce) begin
         cls_valid <= frm_valid;
         if (frm_valid) begin
            cls_queue <= queue_d;
            cls_vlan_pri <= vlan_pri_d;
            cls_tos <= tos_d;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         last_queue_q <= 3'h0;
         last_src_q <= 2'h0;
      end else if (ce && frm_valid) begin
         last_queue_q <= queue_d;
         last_src_q <= src;
      end
   end

   // =====================================================================
   // Egress scheduler
   logic [3:0] credit_q [8];
   logic [2:0] ptr_q;
   logic sp_found;
   logic [2:0] sp_pick;
   logic rr_found;
   logic [2:0] rr_pick;
   logic [2:0] rr_idx;
   logic wrr;
   logic issue;
   logic reload;

   assign wrr = ctrl_q[`QCS_CTRL_WRR];

   // The scan runs upward, so the highest non-empty queue is the last hit and wins.
   always_comb begin
      sp_found = 1'b0;
      sp_pick = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (q_nonempty[i]) begin
            sp_found = 1'b1;
            sp_pick = 3'(i); // RULE12
         end
      end
   end

   // The search starts at the pointer, so a queue keeps its turn until its credit is spent.
   always_comb begin
      rr_found = 1'b0;
      rr_pick = 3'h0;
      rr_idx = 3'h0;
      for (int k = 0; k < 8; k++) begin
         rr_idx = 3'(ptr_q + 3'(k));
         if (!rr_found && q_nonempty[rr_idx] && credit_q[rr_idx] != 4'h0) begin
            rr_found = 1'b1;
            rr_pick = rr_idx; // RULE11
         end
      end
   end

   // A round with no credit left costs one idle cycle for the reload.
   assign issue = sched_ready && (wrr ? rr_found : sp_found);
   assign reload = wrr && sched_ready && sp_found && !rr_found;

   generate
      for (genvar q = 0; q < 8; q++) begin : g_credit
         always_ff @(posedge clk) begin
            if (!resetn) begin
               credit_q[q] <= 4'h0;
            end else if (ce) begin
               if (reload) begin
                  credit_q[q] <= weight_of(weight_q, 3'(q));
               end else if (issue && wrr && rr_pick == 3'(q)) begin
                  credit_q[q] <= credit_q[q] - 4'h1; // RULE11
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ptr_q <= 3'h0;
      end else if (ce && issue && wrr) begin
         ptr_q <= (credit_q[rr_pick] == 4'h1) ? 3'(rr_pick + 3'h1) : rr_pick; // RULE11
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         grant_valid <= 1'b0;
         grant_queue <= 3'h0;
      end else if (ce) begin
         grant_valid <= issue;
         if (issue) begin
            grant_queue <= wrr ? rr_pick : sp_pick; // RULE12
         end
      end
   end

endmodule

// ==== test/qcs_sva.sv ====
// Port checks for the QoS classifier and scheduler.
`include "qcs_map.svh"

module qcs_sva (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   input wire logic [31:0] reg_rdata,
   input wire logic frm_valid,
   input wire logic [7:0] frm_tos,
   input wire logic cls_valid,
   input wire logic [2:0] cls_queue,
   input wire logic [7:0] cls_tos,
   input wire logic [7:0] q_nonempty,
   input wire logic sched_ready,
   input wire logic grant_valid,
   input wire logic [2:0] grant_queue
);
   timeunit 1ns;
   timeprecision 1ps;
   logic en_q;
   logic wrr_q;
   logic [7:0] qn_q;

   // ==========
   // Mode copy
   // The mode sits in a register, so a copy says which checks apply.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         en_q <= 1'b0;
         wrr_q <= 1'b0;
      end else if (ce && reg_we && reg_addr == `QCS_CTRL_OFS) begin
         en_q <= reg_wdata[`QCS_CTRL_EN];
         wrr_q <= reg_wdata[`QCS_CTRL_WRR];
      end
   end

   always_ff @(posedge clk) begin
      qn_q <= q_nonempty;
   end

   // ==========
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_take; ce && frm_valid; endsequence
   sequence s_wr_ctrl; ce && reg_we && reg_addr == `QCS_CTRL_OFS; endsequence
   sequence s_rd_ctrl; ce && reg_re && reg_addr == `QCS_CTRL_OFS; endsequence

   property p_cls_lat; s_take |=> cls_valid; endproperty
   a_cls_lat: assert property (p_cls_lat) else $error("frame not classified");
   property p_cls_src; cls_valid && $past(ce) |-> $past(frm_valid); endproperty
   a_cls_src: assert property (p_cls_src) else $error("result without frame");
   property p_off; cls_valid && !$past(en_q) |-> cls_queue == 3'h0 && cls_tos == $past(frm_tos);
   endproperty
   a_off: assert property (p_off) else $error("disabled classifier altered frame");
   property p_rd_idle; $past(ce) && !$past(reg_re) |-> reg_rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_rd_ctrl;
      s_wr_ctrl ##2 s_rd_ctrl |=> reg_rdata == 32'($past(reg_wdata[3:0], 3));
   endproperty
   a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback differs");
   property p_gnt_src;
      grant_valid && $past(ce) |-> $past(sched_ready) && qn_q[grant_queue];
   endproperty
   a_gnt_src: assert property (p_gnt_src) else $error("grant to idle queue");
   property p_strict; grant_valid && !$past(wrr_q) |-> (qn_q >> grant_queue) == 8'h01; endproperty
   a_strict: assert property (p_strict) else $error("higher queue passed over");
   property p_no_work; q_nonempty == 8'h00 |=> !grant_valid; endproperty
   a_no_work: assert property (p_no_work) else $error("grant with all queues empty");
endmodule

// ==== test/qcs_egress_model.sv ====
// Egress queue manager model: frame counts per queue and a ready line.
module qcs_egress_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic hold,
   input wire logic cls_valid,
   input wire logic [2:0] cls_queue,
   input wire logic grant_valid,
   input wire logic [2:0] grant_queue,
   output logic [7:0] q_nonempty,
   output logic sched_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt [8];

   // ==========
   // Queues
   // One idle cycle after a grant lets the count drop before the next pick.
   assign sched_ready = !hold && !grant_valid;

   always_ff @(posedge clk) begin
      for (int i = 0; i < 8; i++) begin
         cnt[i] <= !resetn ? 0 : cnt[i] + int'(cls_valid && cls_queue == 3'(i))
            - int'(grant_valid && grant_queue == 3'(i));
      end
   end

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         q_nonempty[i] = cnt[i] != 0;
      end
   end
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the QoS classifier and scheduler.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, reg_we = 1'b0, reg_re = 1'b0, hold = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic frm_valid = 1'b0, frm_has_vlan = 1'b0, frm_is_ipv4 = 1'b0;
   logic [2:0] frm_vlan_pri = 3'h0, cls_queue, cls_vlan_pri, grant_queue;
   logic [7:0] frm_tos = 8'h00, cls_tos, q_nonempty;
   logic cls_valid, grant_valid, sched_ready, rd_pend = 1'b0, gchk = 1'b0;
   int failures = 0, n_tests = 0, seed = 2, gpos = 0, wpos = 0, j;
   logic [31:0] rq[$], cq[$], gq[$];
   logic [7:0][2:0] pm = 24'hFAC688, cm = 24'hFAC688;
   logic [2:0] dm [64];
   logic [3:0] ctrl = 4'h0;
   logic [6:0] port = 7'h01;

   always #4 clk = ~clk;
   qcs_classifier_scheduler u_dut (
      .clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .frm_valid(frm_valid),
      .frm_has_vlan(frm_has_vlan), .frm_vlan_pri(frm_vlan_pri), .frm_is_ipv4(frm_is_ipv4),
      .frm_tos(frm_tos), .cls_valid(cls_valid), .cls_queue(cls_queue),
      .cls_vlan_pri(cls_vlan_pri), .cls_tos(cls_tos), .q_nonempty(q_nonempty),
      .sched_ready(sched_ready), .grant_valid(grant_valid), .grant_queue(grant_queue)
   );
   qcs_egress_model u_egr (
      .clk(clk), .resetn(resetn), .hold(hold), .cls_valid(cls_valid), .cls_queue(cls_queue),
      .grant_valid(grant_valid), .grant_queue(grant_queue), .q_nonempty(q_nonempty),
      .sched_ready(sched_ready)
   );

   // ==========
   // Tasks
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      rq.push_back(e);
      @(posedge clk);
      reg_re <= 1'b0;
   endtask

   // Called just after an edge; the caller drops the valid after the last frame.
   task automatic frm(input logic v, input logic [2:0] p, input logic ip, input logic [7:0] t);
      logic [1:0] s;
      logic [2:0] r;
      s = 2'h0;
      if (port[0]) begin
         case (ctrl[2:1])
            2'h0: s = v ? 2'h1 : 2'h0;
            2'h2: s = ip ? 2'h2 : (v ? 2'h1 : 2'h0);
            default: s = ip ? {1'b1, ctrl[2]} : 2'h0;
         endcase
      end
      r = s == 2'h0 ? port[3:1] : s == 2'h1 ? p : t[7:5];
      if (!ctrl[0]) begin
         cq.push_back({18'h0, 3'h0, p, t});
      end else begin
         cq.push_back({18'h0, s == 2'h0 ? pm[port[3:1]] : s == 2'h1 ? pm[p] : s == 2'h2 ?
            dm[t[7:2]] : cm[t[7:5]], port[4] ? r : p, port[5] ? {r, 3'h0, t[1:0]} :
            port[6] ? {r, t[4:0]} : t});
      end
      frm_valid <= 1'b1;
      frm_has_vlan <= v;
      frm_vlan_pri <= p;
      frm_is_ipv4 <= ip;
      frm_tos <= t;
      @(posedge clk);
   endtask

   task automatic drain;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 300 && q_nonempty !== 8'h00; i++) @(posedge clk);
      repeat (3) @(posedge clk);
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ==========
   // Monitor
   always @(posedge clk) begin
      if (rd_pend) cmp(reg_rdata, rq.pop_front());
      if (cls_valid) cmp({18'h0, cls_queue, cls_vlan_pri, cls_tos}, cq.pop_front());
      if (grant_valid) begin
         gpos++;
         if (grant_queue == 3'h0 && wpos == 0) wpos = gpos;
         if (gchk) cmp({29'h0, grant_queue}, gq.pop_front());
      end
      rd_pend <= reg_re;
   end

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      wrap_up;
   end

   // ==========
   // Sequence
   initial begin
      for (int i = 0; i < 64; i++) dm[i] = 3'(i / 8);
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      rd(12'h000, 32'h0);
      rd(12'h004, 32'h1);
      rd(12'h008, 32'hFAC688);
      rd(12'h00C, 32'hFAC688);
      rd(12'h010, 32'h11111111);
      rd(12'h124, 32'h1);
      rd(12'h1FC, 32'h7);
      rd(12'h020, 32'h0);
      // A write while ce is low must not land.
      ce <= 1'b0;
      wr(12'h000, 32'h1);
      ce <= 1'b1;
      rd(12'h000, 32'h0);
      $display("register defaults done");
      for (int k = 0; k < 24; k++) begin
         ctrl = 4'($random(seed)) & 4'h7;
         port = 7'($random(seed));
         pm = 24'($random(seed));
         cm = 24'($random(seed));
         j = $random(seed) & 63;
         dm[j] = 3'($random(seed));
         wr(12'h000, {28'h0, ctrl});
         rd(12'h000, {28'h0, ctrl});
         wr(12'h004, {25'h0, port});
         wr(12'h008, {8'h0, pm});
         wr(12'h00C, {8'h0, cm});
         wr(12'h100 + 12'(j * 4), {29'h0, dm[j]});
         @(posedge clk);
         for (int f = 0; f < 12; f++) begin
            frm(1'($random(seed)), 3'($random(seed)), 1'($random(seed)), 8'($random(seed)));
         end
         frm_valid <= 1'b0;
      end
      drain;
      $display("classification done");
      ctrl = 4'h1;
      port = 7'h01;
      pm = 24'hFAC688;
      wr(12'h000, 32'h1);
      wr(12'h004, 32'h1);
      wr(12'h008, 32'hFAC688);
      hold <= 1'b1;
      @(posedge clk);
      gq.delete();
      frm(1'b1, 3'h2, 1'b0, 8'h00);
      frm(1'b1, 3'h5, 1'b0, 8'h00);
      frm(1'b1, 3'h0, 1'b0, 8'h00);
      frm(1'b1, 3'h7, 1'b0, 8'h00);
      frm(1'b1, 3'h5, 1'b0, 8'h00);
      frm_valid <= 1'b0;
      gq = '{32'h7, 32'h5, 32'h5, 32'h2, 32'h0};
      gchk = 1'b1;
      repeat (2) @(posedge clk);
      hold <= 1'b0;
      drain;
      gchk = 1'b0;
      cmp(32'(gq.size()), 32'h0);
      // Status: last queue 5 from the tag priority, all queues empty.
      rd(12'h014, 32'h0000000D);
      $display("strict priority done");
      ctrl = 4'h9;
      wr(12'h010, 32'h31);
      wr(12'h000, 32'h9);
      hold <= 1'b1;
      @(posedge clk);
      for (int f = 0; f < 7; f++) frm(1'b1, 3'h1, 1'b0, 8'h00);
      frm(1'b1, 3'h0, 1'b0, 8'h00);
      frm_valid <= 1'b0;
      repeat (2) @(posedge clk);
      gpos = 0;
      wpos = 0;
      hold <= 1'b0;
      drain;
      cmp(32'(wpos > 0 && wpos < 8), 32'h1);
      $display("weighted round robin done");
      wrap_up;
   end
endmodule

bind qcs_classifier_scheduler qcs_sva u_sva (
   .clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .frm_valid(frm_valid),
   .frm_tos(frm_tos), .cls_valid(cls_valid), .cls_queue(cls_queue), .cls_tos(cls_tos),
   .q_nonempty(q_nonempty), .sched_ready(sched_ready), .grant_valid(grant_valid),
   .grant_queue(grant_queue)
);
